// file: rtl/fnc_pkg.sv
// Purpose: shared constants and carriers for the fabric nibble cell framer
// Assumes: one nibble per sys_clk, aligned to the fabric cell-start strobe
// Notes: nibble indices count from zero at the cell-start strobe
package fnc_pkg;

    // ==========================================================
    // cell geometry
    localparam int unsigned FNC_IDX_W = 7;
    localparam logic [6:0] FNC_LAST_NIB = 7'd117;
    localparam logic [6:0] FNC_HDR_NIBS = 7'd22;
    localparam logic [6:0] FNC_MARK_NIB = 7'd11;
    localparam logic [6:0] FNC_SEQ_HI_NIB = 7'd20;
    localparam logic [6:0] FNC_HDR_LAST_NIB = 7'd21;
    localparam logic [6:0] FNC_PAY_FIRST_NIB = 7'd22;
    localparam logic [8:0] FNC_HDR_TOP_BIT = 9'd87;
    localparam int unsigned FNC_HDR_BITS = 88;

    // ==========================================================
    // field positions and codes
    localparam logic [1:0] FNC_PRES_VALID = 2'b10;
    localparam int unsigned FNC_MARK_BIT = 1;
    localparam int unsigned FNC_PARITY_BIT = 0;

    // ==========================================================
    // idle cell content
    localparam logic [3:0] FNC_IDLE_PRES = 4'h4;
    localparam logic [3:0] FNC_IDLE_ZERO = 4'h0;
    localparam logic [3:0] FNC_MARCH_0 = 4'h8;
    localparam logic [3:0] FNC_MARCH_1 = 4'h4;
    localparam logic [3:0] FNC_MARCH_2 = 4'h2;
    localparam logic [3:0] FNC_MARCH_3 = 4'h1;
    localparam logic [3:0] FNC_OOS_MARK = 4'ha;

    // ==========================================================
    // buffering and counters
    localparam int unsigned FNC_PAY_W = 8;
    localparam int unsigned FNC_FIFO_DEPTH = 4;
    localparam int unsigned FNC_SYNC_W = 5;
    localparam logic [3:0] FNC_CNT_RST = 4'h0;

    // header fields of a data cell, nibbles 0 to 21 less the presence code
    typedef struct packed {
        logic multicast;
        logic pres_spare;
        logic [1:0] route_spare;
        logic [1:0] priority_lvl;
        logic [31:0] route_tags;
        logic [1:0] spare_bits;
        logic mark_flag;
        logic parity;
        logic [15:0] output_channel_field;
        logic [15:0] vci;
        logic [2:0] pti;
        logic clp;
        logic [7:0] sequence_field;
    } fnc_hdr_s;

endpackage

// file: rtl/fnc_sync.sv
// Purpose: two-stage synchroniser for fabric pin inputs
// Assumes: pins are asynchronous to sys_clk
// Notes: the first stage feeds only the second
`timescale 1ns/100ps
module fnc_sync #(
    parameter int unsigned W = 1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync <= '0;
        end else if (clk_en) begin
            meta_q <= pin;
            sync <= meta_q;
        end
    end
endmodule

// file: rtl/fnc_fifo.sv
// Purpose: small payload byte fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: out_data comes straight from the storage flops
`timescale 1ns/100ps
module fnc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

// file: rtl/fnc_framer.sv
// Purpose: builds 118-nibble fabric cells, data and idle, and parses received data cells
// Assumes: strobe and nibble pins arrive asynchronously and are synchronised here
// Notes: tx cells are slotted on the rx cell-start strobe; payload comes through a fifo
`timescale 1ns/100ps
module fnc_framer (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // fabric pins
    input wire logic fab_rx_soc,
    input wire logic [3:0] fab_rx_nib,
    output logic fab_tx_soc,
    output logic [3:0] fab_tx_nib,
    // transmit header and payload
    input wire logic tx_hdr_valid,
    output logic tx_hdr_ready,
    input wire fnc_pkg::fnc_hdr_s tx_hdr,
    input wire logic tx_pay_valid,
    output logic tx_pay_ready,
    input wire logic [7:0] tx_pay_data,
    input wire logic tx_underrun_clr,
    output logic tx_underrun,
    // receive side
    output logic rx_hdr_valid,
    output fnc_pkg::fnc_hdr_s rx_hdr,
    output logic rx_parity_err,
    output logic rx_byte_valid,
    output logic rx_byte_last,
    output logic [7:0] rx_byte,
    // status
    output logic in_sync,
    output logic [3:0] tx_marked_cnt,
    output logic [3:0] rx_marked_cnt
);
    import fnc_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic rx_soc_s;
    logic [3:0] rx_nib_s;

    fnc_sync #(.W(FNC_SYNC_W)) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pin({fab_rx_soc, fab_rx_nib}),
        .sync({rx_soc_s, rx_nib_s})
    );

    // ==========================================================
    // nibble index and strobe checking
    logic [6:0] cnt_q;
    logic seen_q;
    logic sync_q;

    wire [6:0] idx = rx_soc_s ? 7'd0 : cnt_q;
    wire [6:0] cnt_d = (idx == FNC_LAST_NIB) ? 7'd0 : idx + 7'd1;
    // a strobe is good only when it lands a whole number of cells after the last one
    wire soc_good = rx_soc_s && seen_q && (cnt_q == 7'd0);
    wire soc_missing = !rx_soc_s && seen_q && (cnt_q == 7'd0);
    wire sync_d = rx_soc_s ? soc_good : (soc_missing ? 1'b0 : sync_q);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 7'd0;
            seen_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            seen_q <= seen_q | rx_soc_s;
            sync_q <= sync_d;
        end
    end

    assign in_sync = sync_q;

    // ==========================================================
    // transmit cell selection
    fnc_hdr_s cur_hdr_q;
    logic data_q;
    logic [3:0] lo_q;

    wire is_first = (idx == 7'd0);
    wire take = is_first && sync_q && tx_hdr_valid;
    // a header is only offered a slot while in sync; otherwise idles go out
    assign tx_hdr_ready = is_first && sync_q;
    wire is_data = is_first ? take : data_q;
    fnc_hdr_s hsel;
    assign hsel = is_first ? tx_hdr : cur_hdr_q;

    // ==========================================================
    // data cell header nibbles, nibble 0 in the top four bits
    wire [FNC_HDR_BITS-1:0] hdr_nibs = {
        FNC_PRES_VALID, hsel.multicast, hsel.pres_spare,
        hsel.route_spare, hsel.priority_lvl,
        hsel.route_tags,
        hsel.output_channel_field[15:12],
        hsel.spare_bits, hsel.mark_flag, hsel.parity,
        hsel.output_channel_field[11:0],
        hsel.vci,
        hsel.pti, hsel.clp,
        hsel.sequence_field
    };
    wire in_hdr = (idx < FNC_HDR_NIBS);
    wire [8:0] hpos = FNC_HDR_TOP_BIT - {idx[4:0], 2'b00};
    wire [3:0] hdr_nib = hdr_nibs[hpos[6:0] -: 4];

    // ==========================================================
    // payload nibbles from the fifo, high nibble of each byte first
    logic fifo_valid;
    logic [7:0] fifo_data;
    wire pay_hi = !in_hdr && !idx[0];
    wire pop = is_data && pay_hi && fifo_valid;
    wire underrun_ev = is_data && pay_hi && !fifo_valid;
    wire [3:0] pay_nib = pay_hi ? (fifo_valid ? fifo_data[7:4] : 4'h0) : lo_q;
    wire [3:0] lo_d = pay_hi ? (fifo_valid ? fifo_data[3:0] : 4'h0) : lo_q;

    fnc_fifo #(.WIDTH(FNC_PAY_W), .DEPTH(FNC_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .in_valid(tx_pay_valid),
        .in_ready(tx_pay_ready),
        .in_data(tx_pay_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // ==========================================================
    // idle cell nibbles
    wire [3:0] march2 = sync_q ? FNC_MARCH_0 : FNC_OOS_MARK;
    wire [3:0] idle_nib =
        (idx == 7'd0) ? FNC_IDLE_PRES :
        (idx == 7'd1) ? FNC_IDLE_ZERO :
        (idx == 7'd2) ? march2 :
        (idx == 7'd3) ? FNC_MARCH_1 :
        (idx == 7'd4) ? FNC_MARCH_2 :
        (idx == 7'd5) ? FNC_MARCH_3 :
        FNC_IDLE_ZERO;

    wire [3:0] tx_nib_d = is_data ? (in_hdr ? hdr_nib : pay_nib) : idle_nib;
    wire tx_mark_ev = is_data && (idx == FNC_MARK_NIB) && hsel.mark_flag;

    // ==========================================================
    // transmit registers
    logic [3:0] tx_nib_q;
    logic tx_soc_q;
    logic [6:0] out_idx_q;
    logic out_data_q;
    logic out_sync_q;
    logic underrun_q;
    logic [3:0] tx_mark_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_nib_q <= 4'h0;
            tx_soc_q <= 1'b0;
            out_idx_q <= 7'd0;
            out_data_q <= 1'b0;
            out_sync_q <= 1'b0;
            data_q <= 1'b0;
            lo_q <= 4'h0;
        end else if (clk_en) begin
            tx_nib_q <= tx_nib_d;
            tx_soc_q <= is_first;
            out_idx_q <= idx;
            out_data_q <= is_data;
            out_sync_q <= sync_q;
            data_q <= is_data;
            lo_q <= lo_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && take) begin
            cur_hdr_q <= tx_hdr;
        end
    end

    // a fresh underrun wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            underrun_q <= 1'b0;
            tx_mark_q <= FNC_CNT_RST;
        end else if (clk_en) begin
            underrun_q <= underrun_ev | (underrun_q & !tx_underrun_clr);
            tx_mark_q <= tx_mark_ev ? tx_mark_q + 4'h1 : tx_mark_q;
        end
    end

    assign fab_tx_nib = tx_nib_q;
    assign fab_tx_soc = tx_soc_q;
    assign tx_underrun = underrun_q;
    assign tx_marked_cnt = tx_mark_q;

    // ==========================================================
    // receive parsing
    logic [FNC_HDR_BITS-5:0] rx_sh_q;
    logic rx_pres_q;
    logic rx_par_q;
    logic [3:0] rx_hi_q;
    logic rx_hdr_v_q;
    logic rx_perr_q;
    logic rx_bv_q;
    logic rx_bl_q;
    logic [7:0] rx_byte_q;
    logic [3:0] rx_mark_q;
    fnc_hdr_s rx_hdr_q;

    // received cells are only trusted while the strobe is in step
    wire rx_live = sync_d;
    wire pres_now = is_first ? (rx_nib_s[3:2] == FNC_PRES_VALID) : rx_pres_q;
    wire rx_cell = rx_live && pres_now;
    wire par_run = is_first ? ^rx_nib_s : (rx_par_q ^ (^rx_nib_s));
    wire rx_mark_ev = rx_cell && (idx == FNC_MARK_NIB) && rx_nib_s[FNC_MARK_BIT];
    wire rx_par_ev = rx_cell && (idx == FNC_MARK_NIB) && !par_run;
    wire rx_hdr_ev = rx_cell && (idx == FNC_HDR_LAST_NIB);
    wire [FNC_HDR_BITS-1:0] rx_all = {rx_sh_q, rx_nib_s};
    wire rx_lo_ev = rx_cell && !in_hdr && idx[0];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sh_q <= '0;
            rx_pres_q <= 1'b0;
            rx_par_q <= 1'b0;
            rx_hi_q <= 4'h0;
        end else if (clk_en) begin
            rx_sh_q <= in_hdr ? {rx_sh_q[FNC_HDR_BITS-9:0], rx_nib_s} : rx_sh_q;
            rx_pres_q <= pres_now;
            rx_par_q <= par_run;
            rx_hi_q <= rx_nib_s;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_hdr_v_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_bv_q <= 1'b0;
            rx_bl_q <= 1'b0;
            rx_byte_q <= 8'h00;
            rx_mark_q <= FNC_CNT_RST;
            rx_hdr_q <= '0;
        end else if (clk_en) begin
            rx_hdr_v_q <= rx_hdr_ev;
            rx_perr_q <= rx_par_ev ? 1'b1 : (is_first ? 1'b0 : rx_perr_q);
            rx_bv_q <= rx_lo_ev;
            rx_bl_q <= rx_lo_ev && (idx == FNC_LAST_NIB);
            rx_byte_q <= rx_lo_ev ? {rx_hi_q, rx_nib_s} : rx_byte_q;
            rx_mark_q <= rx_mark_ev ? rx_mark_q + 4'h1 : rx_mark_q;
            if (rx_hdr_ev) begin
                // strip the presence code and swap nibbles 10 and 11 to line up with the struct
                // nibble 10 carries the top of the channel field, after the route tags
                rx_hdr_q <= fnc_hdr_s'({rx_all[85:48], rx_all[43:40], rx_all[47:44],
                    rx_all[39:0]});
            end
        end
    end

    assign rx_hdr_valid = rx_hdr_v_q;
    assign rx_hdr = rx_hdr_q;
    assign rx_parity_err = rx_perr_q;
    assign rx_byte_valid = rx_bv_q;
    assign rx_byte_last = rx_bl_q;
    assign rx_byte = rx_byte_q;
    assign rx_marked_cnt = rx_mark_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b || !clk_en);

    sequence s_march;
        fab_tx_nib == FNC_MARCH_1 ##1 fab_tx_nib == FNC_MARCH_2
            ##1 fab_tx_nib == FNC_MARCH_3;
    endsequence

    sequence s_seq_out;
        fab_tx_nib == cur_hdr_q.sequence_field[7:4]
            ##1 fab_tx_nib == cur_hdr_q.sequence_field[3:0];
    endsequence

    property p_idle_pres;
        fab_tx_soc && !out_data_q |-> fab_tx_nib == FNC_IDLE_PRES;
    endproperty
    a_idle_pres: assert property (p_idle_pres) else $error("idle nibble 0 wrong");

    property p_idle_one;
        out_idx_q == 7'd1 && !out_data_q |-> fab_tx_nib == FNC_IDLE_ZERO;
    endproperty
    a_idle_one: assert property (p_idle_one) else $error("idle nibble 1 wrong");

    // while out of step no header may claim a slot
    property p_oos_idle;
        fab_tx_soc && !out_sync_q |-> !out_data_q;
    endproperty
    a_oos_idle: assert property (p_oos_idle) else $error("data cell while out of sync");

    property p_march_seq;
        out_idx_q == 7'd3 && !out_data_q |-> s_march;
    endproperty
    a_march_seq: assert property (p_march_seq) else $error("marching one broken");

    property p_oos;
        out_idx_q == 7'd2 && !out_data_q |->
            fab_tx_nib == (out_sync_q ? FNC_MARCH_0 : FNC_OOS_MARK);
    endproperty
    a_oos: assert property (p_oos) else $error("idle nibble 2 wrong");

    property p_idle_zero;
        out_idx_q > 7'd5 && !out_data_q |-> fab_tx_nib == FNC_IDLE_ZERO;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle tail not zero");

    property p_data_pres;
        fab_tx_soc && out_data_q |-> fab_tx_nib[3:2] == FNC_PRES_VALID && in_sync;
    endproperty
    a_data_pres: assert property (p_data_pres) else $error("data presence bad");

    property p_seq;
        out_idx_q == FNC_SEQ_HI_NIB && out_data_q |-> s_seq_out;
    endproperty
    a_seq: assert property (p_seq) else $error("sequence field order");

    property p_rx_mark;
        rx_mark_ev |=> rx_marked_cnt == $past(rx_marked_cnt) + 4'h1;
    endproperty
    a_rx_mark: assert property (p_rx_mark) else $error("rx mark count missed");

    property p_idx_restart;
        rx_soc_s |=> cnt_q == 7'd1;
    endproperty
    a_idx_restart: assert property (p_idx_restart) else $error("index not restarted");

    property p_mark_pos;
        out_idx_q == FNC_MARK_NIB && out_data_q |->
            fab_tx_nib == {cur_hdr_q.spare_bits, cur_hdr_q.mark_flag, cur_hdr_q.parity};
    endproperty
    a_mark_pos: assert property (p_mark_pos) else $error("nibble 11 layout");

endmodule

// file: bench/fnc_fabric_model.sv
// Purpose: fabric element model, sends cells on the rx pins and captures sent cells
// Assumes: pins change half a nanosecond after the rising edge
// Notes: with run low the nibble line toggles every cycle, so no stale nibble lingers
`timescale 1ns/100ps
module fnc_fabric_model (
    input wire logic sys_clk,
    input wire logic fab_tx_soc,
    input wire logic [3:0] fab_tx_nib,
    output logic fab_rx_soc,
    output logic [3:0] fab_rx_nib
);
    logic [3:0] nxt [118];
    logic [3:0] cap [118];
    int cap_n = 118;
    int slot = 0;
    int per = 118;
    bit run = 1'b0;
    bit pend = 1'b0;
    bit use_d = 1'b0;

    function automatic logic [3:0] idle_nib(int i, bit s);
        case (i)
            0: return 4'h4;
            2: return s ? 4'h8 : 4'ha;
            3: return 4'h4;
            4: return 4'h2;
            5: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction

    initial begin
        fab_rx_soc = 1'b0;
        fab_rx_nib = 4'h0;
    end

    // ==========================================================
    // cell source, one nibble per clock
    always @(posedge sys_clk) begin
        #0.5;
        if (!run) begin
            fab_rx_soc = 1'b0;
            fab_rx_nib = ~fab_rx_nib;
            slot = 0;
        end else begin
            if (slot == 0) begin
                use_d = pend;
                pend = 1'b0;
            end
            fab_rx_soc = (slot == 0);
            fab_rx_nib = use_d ? nxt[slot] : idle_nib(slot, 1'b1);
            // a shortened period makes one early strobe on purpose
            slot = (slot + 1 >= per) ? 0 : slot + 1;
        end
    end

    // ==========================================================
    // capture of the cells sent by the framer
    // sampled mid-cycle, where the framer's registered pins have settled
    always @(negedge sys_clk) begin
        if (fab_tx_soc) begin
            cap[0] = fab_tx_nib;
            cap_n = 1;
        end else if (cap_n < 118) begin
            cap[cap_n] = fab_tx_nib;
            cap_n++;
        end
    end
endmodule

// file: bench/tb_top.sv
// Purpose: self-checking bench for the fabric nibble cell framer
// Assumes: the fabric model paces cells at 118 clocks
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module tb_top;
    import fnc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic fab_rx_soc, fab_tx_soc, tx_hdr_ready, tx_pay_ready, tx_underrun;
    logic [3:0] fab_rx_nib, fab_tx_nib, tx_marked_cnt, rx_marked_cnt;
    logic tx_hdr_valid = 1'b0;
    logic tx_pay_valid = 1'b0;
    logic tx_underrun_clr = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] tx_pay_data = 8'h00;
    fnc_hdr_s tx_hdr = '0;
    fnc_hdr_s rx_hdr;
    logic rx_hdr_valid, rx_parity_err, rx_byte_valid, rx_byte_last, in_sync;
    logic [7:0] rx_byte;
    int miscompares = 0;
    int n_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    fnc_framer uut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .fab_rx_soc(fab_rx_soc), .fab_rx_nib(fab_rx_nib), .fab_tx_soc(fab_tx_soc),
        .fab_tx_nib(fab_tx_nib), .tx_hdr_valid(tx_hdr_valid), .tx_hdr_ready(tx_hdr_ready),
        .tx_hdr(tx_hdr), .tx_pay_valid(tx_pay_valid), .tx_pay_ready(tx_pay_ready),
        .tx_pay_data(tx_pay_data), .tx_underrun_clr(tx_underrun_clr),
        .tx_underrun(tx_underrun), .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr),
        .rx_parity_err(rx_parity_err), .rx_byte_valid(rx_byte_valid),
        .rx_byte_last(rx_byte_last), .rx_byte(rx_byte), .in_sync(in_sync),
        .tx_marked_cnt(tx_marked_cnt), .rx_marked_cnt(rx_marked_cnt));

    fnc_fabric_model fab (.sys_clk(sys_clk), .fab_tx_soc(fab_tx_soc),
        .fab_tx_nib(fab_tx_nib), .fab_rx_soc(fab_rx_soc), .fab_rx_nib(fab_rx_nib));

    // ==========================================================
    // shared helpers
    task automatic end_sim;
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [87:0] seen, logic [87:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    function automatic logic pick(int sel);
        case (sel)
            0: return fab_tx_soc;
            1: return tx_hdr_ready;
            2: return in_sync;
            default: return fab_rx_soc;
        endcase
    endfunction

    task automatic wait_val(int sel, logic v, int lim);
        for (int n = 0; pick(sel) !== v; n++) begin
            if (n == lim) begin
                miscompares++;
                $display("BAD wait %0d exp %b seen timeout", sel, v);
                end_sim();
            end
            tick();
        end
    endtask

    function automatic logic [7:0] pay(int k);
        return 8'(k) * 8'h25 + 8'h05;
    endfunction

    // wire order of header nibbles 0 to 21
    function automatic logic [87:0] cellv(fnc_hdr_s h, logic [1:0] pres);
        return {pres, h.multicast, h.pres_spare, h.route_spare, h.priority_lvl, h.route_tags,
            h.output_channel_field[15:12], h.spare_bits, h.mark_flag, h.parity,
            h.output_channel_field[11:0], h.vci, h.pti, h.clp, h.sequence_field};
    endfunction

    function automatic fnc_hdr_s mk_hdr(logic mark);
        fnc_hdr_s h;
        logic [87:0] v;
        h = fnc_hdr_s'({1'b1, 1'b0, 2'h1, 2'h3, 32'h1234_5678, 2'h2, mark, 1'b0,
            16'hbeef, 16'h0a5c, 3'h5, 1'b1, 8'h96});
        v = cellv(h, 2'b10);
        h.parity = ~^v[87:40];
        return h;
    endfunction

    // waits for a sent cell and for its last nibble to be captured
    task automatic get_cell(output logic s);
        wait_val(0, 1'b1, 400);
        s = in_sync;
        tick();
        for (int n = 0; fab.cap_n != 118; n++) begin
            if (n == 200) begin
                wait_val(0, 1'bz, 0);
            end
            tick();
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk("hdr_ready", tx_hdr_ready, 1'b0);
        chk("pay_ready", tx_pay_ready, 1'b1);
        chk("status", {in_sync, tx_underrun, tx_marked_cnt, rx_marked_cnt}, 10'h0);
    endtask

    // without the freeze the first cell start would show at the first edge
    task automatic t_freeze;
        clk_en = 1'b0;
        repeat (3) begin
            tick();
            chk("frozen soc", fab_tx_soc, 1'b0);
        end
        clk_en = 1'b1;
        fab.run = 1'b1;
        tick();
        chk("thawed soc", fab_tx_soc, 1'b1);
    endtask

    task automatic t_idle(logic exp_s);
        logic s;
        get_cell(s);
        chk("idle sync", s, exp_s);
        for (int i = 0; i < 118; i++) begin
            chk("idle nib", fab.cap[i], fab.idle_nib(i, exp_s));
        end
    endtask

    task automatic t_tx;
        fnc_hdr_s h;
        logic [87:0] v;
        logic s;
        int k;
        h = mk_hdr(1'b1);
        v = cellv(h, 2'b10);
        k = 0;
        while (tx_pay_ready === 1'b1 && k < 8) begin
            tx_pay_data = pay(k);
            tx_pay_valid = 1'b1;
            tick();
            k++;
        end
        tx_pay_valid = 1'b0;
        chk("fifo fill", k, 4);
        tx_hdr = h;
        tx_hdr_valid = 1'b1;
        wait_val(1, 1'b1, 300);
        tick();
        tx_hdr_valid = 1'b0;
        get_cell(s);
        for (int i = 0; i < 22; i++) begin
            chk("tx hdr nib", fab.cap[i], v[87-4*i -: 4]);
        end
        for (int i = 0; i < 48; i++) begin
            chk("tx pay", {fab.cap[22+2*i], fab.cap[23+2*i]}, i < 4 ? pay(i) : 8'h00);
        end
        chk("underrun", tx_underrun, 1'b1);
        chk("tx mark cnt", tx_marked_cnt, 4'h1);
        tx_underrun_clr = 1'b1;
        tick();
        tx_underrun_clr = 1'b0;
        tick();
        chk("underrun clr", tx_underrun, 1'b0);
    endtask

    task automatic t_rx(logic mark, logic bad, logic [1:0] pres);
        fnc_hdr_s h;
        logic [87:0] v;
        logic [3:0] cnt;
        int k;
        int hv;
        h = mk_hdr(mark);
        h.parity = h.parity ^ bad;
        v = cellv(h, pres);
        for (int i = 0; i < 22; i++) begin
            fab.nxt[i] = v[87-4*i -: 4];
        end
        for (int i = 0; i < 48; i++) begin
            {fab.nxt[22+2*i], fab.nxt[23+2*i]} = pay(i + 9);
        end
        cnt = rx_marked_cnt + {3'h0, mark & (pres == 2'b10)};
        fab.pend = 1'b1;
        k = 0;
        hv = 0;
        repeat (260) begin
            tick();
            if (rx_hdr_valid === 1'b1) begin
                chk("rx hdr", rx_hdr, h);
                chk("rx parity err", rx_parity_err, bad);
                hv++;
            end
            if (rx_byte_valid === 1'b1) begin
                chk("rx byte", rx_byte, pay(k + 9));
                chk("rx last", rx_byte_last, k == 47);
                k++;
            end
        end
        chk("rx cells", hv, pres == 2'b10 ? 1 : 0);
        chk("rx bytes", k, pres == 2'b10 ? 48 : 0);
        chk("rx mark cnt", rx_marked_cnt, cnt);
    endtask

    task automatic t_resync;
        // start from a strobe so that the shortened period always lands early
        wait_val(3, 1'b1, 200);
        fab.per = 60;
        tick();
        wait_val(3, 1'b1, 200);
        fab.per = 118;
        t_idle(1'b0);
        wait_val(2, 1'b1, 600);
        t_idle(1'b1);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_freeze();
        t_idle(1'b0);
        wait_val(2, 1'b1, 600);
        t_idle(1'b1);
        t_tx();
        t_rx(1'b1, 1'b0, 2'b10);
        t_rx(1'b0, 1'b1, 2'b10);
        t_rx(1'b1, 1'b0, 2'b00);
        t_rx(1'b1, 1'b0, 2'b11);
        t_resync();
        end_sim();
    end

    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
endmodule
